// >>> rtl/fpes_regs.svh
// Purpose: Register offsets, fields and timing counts of the flash host
// Assumes: 200 MHz clock
// Notes:   Guarded; definitions only
`ifndef FPES_REGS_SVH
`define FPES_REGS_SVH
`define FPES_OFS_CTRL        4'h0
`define FPES_OFS_ADDR        4'h1
`define FPES_OFS_DATA        4'h2
`define FPES_OFS_STAT        4'h3
`define FPES_OFS_RDATA       4'h4
`define FPES_CMD_LSB         0
`define FPES_CMD_W           3
`define FPES_STAT_BUSY       0
`define FPES_STAT_DONE       1
`define FPES_STAT_TOUT       2
`define FPES_STAT_SUSP       3
`define FPES_STAT_OK         4
`define FPES_RESET_VAL       32'h0000_0000
`define FPES_UNLOCK1_ADDR    18'h00555
`define FPES_UNLOCK2_ADDR    18'h00aaa
`define FPES_UNLOCK1_DATA    8'haa
`define FPES_UNLOCK2_DATA    8'h55
`define FPES_PROG_DATA       8'ha0
`define FPES_ERASE_DATA      8'h80
`define FPES_CHIP_DATA       8'h10
`define FPES_SECT_DATA       8'h30
`define FPES_SUSP_DATA       8'hb0
`define FPES_RESET_DATA      8'hf0
`define FPES_ID_DATA         8'h90
`define FPES_PROT_OFS        18'h00002
`define FPES_SECT_MASK       18'h3e000
`define FPES_POLL_BIT        7
`define FPES_TOUT_BIT        5
// Strobe phase lengths: 60 ns setup, 60 ns pulse, 60 ns recovery
`define FPES_PHASE_NS        60
`define FPES_CLK_MHZ         200
`define FPES_PHASE_CYC       ((`FPES_PHASE_NS*`FPES_CLK_MHZ+999)/1000)
`endif

// >>> rtl/fpes_pkg.sv
// Purpose: Types of the flash program and erase host
// Assumes: Used with fpes_regs.svh
// Notes:   Host commands to the flash
package fpes_pkg;
  typedef enum logic [2:0] {
    FPES_OP_NONE,
    FPES_OP_READ,
    FPES_OP_PROG,
    FPES_OP_CHIP,
    FPES_OP_SECT,
    FPES_OP_SUSP,
    FPES_OP_RESUME,
    FPES_OP_PROT
  } fpes_op_t;
endpackage

// >>> rtl/fpes_bus_cycle.sv
// Purpose: One timed flash bus cycle, read or write
// Assumes: Single 200 MHz clock; flash data pins synchronised here
// Notes:   Setup, strobe and recovery phases of equal length
`timescale 1ns/1ps
`include "fpes_regs.svh"
module fpes_bus_cycle
  import fpes_pkg::*;
(
  input  wire logic        clk,         // System clock
  input  wire logic        reset_n,     // Async reset, active low
  input  wire logic        start,       // Begin a cycle, one pulse
  input  wire logic        wr,          // 1 write, 0 read
  input  wire logic [17:0] addr,        // Flash address
  input  wire logic [7:0]  wdata,       // Write byte
  output logic             busy,        // Cycle running
  output logic             done,        // Cycle end pulse
  output logic [7:0]       rdata,       // Byte read
  output logic [17:0]      flash_addr,  // Address pins
  output logic             chip_sel_n,  // Chip select
  output logic             write_en_n,  // Write strobe
  output logic             out_en_n,    // Output strobe
  output logic [7:0]       dq_out,      // Data pins out
  output logic             dq_oe_n,     // Data drive enable, low drives
  input  wire logic [7:0]  dq_in        // Data pins in
);
  typedef enum logic [1:0] {FPES_BC_IDLE, FPES_BC_SETUP, FPES_BC_PULSE,
                            FPES_BC_REC} fpes_bc_t;
  localparam logic [7:0] PHASE = 8'(`FPES_PHASE_CYC);
  fpes_bc_t   st_q;
  logic [7:0] cnt_q;
  logic       wr_q;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;

  // ==========================================================
  // Input synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= dq_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // Phase sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q       <= FPES_BC_IDLE;
      cnt_q      <= 8'h00;
      wr_q       <= 1'b0;
      flash_addr <= 18'h00000;
      dq_out     <= 8'h00;
      dq_oe_n    <= 1'b1;
      chip_sel_n <= 1'b1;
      write_en_n <= 1'b1;
      out_en_n   <= 1'b1;
      rdata      <= 8'h00;
      done       <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_q)
        FPES_BC_IDLE: begin
          if (start) begin
            st_q       <= FPES_BC_SETUP;
            cnt_q      <= PHASE;
            wr_q       <= wr;
            flash_addr <= addr;
            dq_out     <= wdata;
            dq_oe_n    <= !wr;
            chip_sel_n <= 1'b0;
          end
        end
        FPES_BC_SETUP: begin
          if (cnt_q == 8'h01) begin
            st_q  <= FPES_BC_PULSE;
            cnt_q <= PHASE;
            if (wr_q) write_en_n <= 1'b0;
            else out_en_n <= 1'b0;
          end else cnt_q <= cnt_q - 8'h01;
        end
        FPES_BC_PULSE: begin
          if (cnt_q == 8'h01) begin
            st_q       <= FPES_BC_REC;
            cnt_q      <= PHASE;
            write_en_n <= 1'b1;
            out_en_n   <= 1'b1;
            if (!wr_q) rdata <= sync2_q;
          end else cnt_q <= cnt_q - 8'h01;
        end
        FPES_BC_REC: begin
          if (cnt_q == 8'h01) begin
            st_q       <= FPES_BC_IDLE;
            chip_sel_n <= 1'b1;
            dq_oe_n    <= 1'b1;
            done       <= 1'b1;
          end else cnt_q <= cnt_q - 8'h01;
        end
        default: st_q <= FPES_BC_IDLE;
      endcase
    end
  end

  assign busy = (st_q != FPES_BC_IDLE);
endmodule

// >>> rtl/fpes_host.sv
// Purpose: Host that programs, erases and polls a parallel flash
// Assumes: Avalon-MM slave at 200 MHz; flash pins on one clock
// Notes:   Command in CTRL starts its write sequence and polling; read skips both, protect query skips polling
`timescale 1ns/1ps
`include "fpes_regs.svh"
// Operation
// - Program sends two unlocks, program setup, then address and byte.
// - Program only clears bits; software erases first to restore ones.
// - Timeout bit seen high ends polling and sends reset command.
// - Chip erase sends six writes ending with chip erase command.
// - Sector erase ends with 30h written at an address in the sector.
// - Only one sector erase at a time; new ones refused while busy.
// - Poll address lies inside the programmed or erased sector.
// - After program or erase polling ends without timeout, one more read fetches valid data.
module fpes_host
  import fpes_pkg::*;
(
  input  wire logic        clk,               // 200 MHz clock
  input  wire logic        reset_n,           // Async reset, active low
  input  wire logic [3:0]  avs_address,       // Word address
  input  wire logic        avs_read,          // Read request
  input  wire logic        avs_write,         // Write request
  input  wire logic [31:0] avs_writedata,     // Write data
  output logic [31:0]      avs_readdata,      // Read data
  output logic             avs_waitrequest,   // Stall
  output logic [17:0]      flash_addr,        // Flash address pins
  output logic             chip_select_n,     // Flash chip select
  output logic             write_strobe_n,    // Flash write strobe
  output logic             output_strobe_n,   // Flash output strobe
  output logic [7:0]       dq_out,            // Flash data out
  output logic             dq_oe_n,           // Data drive, low drives
  input  wire logic [7:0]  dq_in              // Flash data in
);
  typedef enum logic [2:0] {FPES_S_IDLE, FPES_S_WRITE, FPES_S_POLL,
                            FPES_S_FINAL, FPES_S_RESET} fpes_st_t;

  fpes_st_t   st_q;
  fpes_op_t   op_q;
  logic [2:0] step_q;
  logic [2:0] nsteps_q;
  logic [17:0] addr_q;
  logic [7:0]  data_q;
  logic [7:0]  rdata_q;
  logic        busy_q, done_q, tout_q, susp_q, sect_run_q, ok_q;
  logic        bc_start_q, bc_wr_q;
  logic [17:0] bc_addr_q;
  logic [7:0]  bc_wdata_q;
  logic        bc_busy, bc_done;
  logic [7:0]  bc_rdata;
  logic        cmd_wr;
  logic        rd_ack_q;
  fpes_op_t    cmd_op;

  function automatic logic [17:0] seq_addr(input fpes_op_t op,
                                           input logic [2:0] s,
                                           input logic [17:0] a);
    // sector chosen by upper bits only
    logic [17:0] sa;
    sa = a & `FPES_SECT_MASK;
    case (s)
      3'd0, 3'd2: seq_addr = `FPES_UNLOCK1_ADDR;
      3'd1, 3'd4: seq_addr = `FPES_UNLOCK2_ADDR;
      3'd3: seq_addr = (op == FPES_OP_PROG) ? a : `FPES_UNLOCK1_ADDR;
      default: seq_addr = (op == FPES_OP_SECT) ? sa : `FPES_UNLOCK1_ADDR;
    endcase
  endfunction

  function automatic logic [7:0] seq_data(input fpes_op_t op,
                                          input logic [2:0] s,
                                          input logic [7:0] d);
    case (s)
      3'd0, 3'd3: seq_data = `FPES_UNLOCK1_DATA;
      3'd1, 3'd4: seq_data = `FPES_UNLOCK2_DATA;
      3'd2: seq_data = (op == FPES_OP_PROG) ? `FPES_PROG_DATA :
                       (op == FPES_OP_PROT) ? `FPES_ID_DATA :
                       `FPES_ERASE_DATA;
      default: seq_data = (op == FPES_OP_CHIP) ? `FPES_CHIP_DATA :
                          `FPES_SECT_DATA;
    endcase
    // byte sent as given; flash only clears bits
    if (op == FPES_OP_PROG && s == 3'd3) seq_data = d;
  endfunction

  assign cmd_op = fpes_op_t'(avs_writedata[`FPES_CMD_LSB +: `FPES_CMD_W]);
  assign cmd_wr = avs_write && avs_address == `FPES_OFS_CTRL;
  // One wait state per read so read data stand when waitrequest drops
  assign avs_waitrequest = avs_read && !rd_ack_q;

  fpes_bus_cycle u_cycle (
    .clk        (clk),
    .reset_n    (reset_n),
    .start      (bc_start_q),
    .wr         (bc_wr_q),
    .addr       (bc_addr_q),
    .wdata      (bc_wdata_q),
    .busy       (bc_busy),
    .done       (bc_done),
    .rdata      (bc_rdata),
    .flash_addr (flash_addr),
    .chip_sel_n (chip_select_n),
    .write_en_n (write_strobe_n),
    .out_en_n   (output_strobe_n),
    .dq_out     (dq_out),
    .dq_oe_n    (dq_oe_n),
    .dq_in      (dq_in)
  );

  // ==========================================================
  // Register file
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= 18'h00000;
      data_q <= 8'h00;
    end else if (avs_write && !busy_q) begin
      if (avs_address == `FPES_OFS_ADDR) addr_q <= avs_writedata[17:0];
      if (avs_address == `FPES_OFS_DATA) data_q <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rd_ack_q <= 1'b0;
    else rd_ack_q <= avs_read && !rd_ack_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) avs_readdata <= `FPES_RESET_VAL;
    else if (avs_read && !rd_ack_q) begin
      case (avs_address)
        `FPES_OFS_ADDR: avs_readdata <= {14'h0000, addr_q};
        `FPES_OFS_DATA: avs_readdata <= {24'h000000, data_q};
        `FPES_OFS_STAT: avs_readdata <= {27'h0000000, ok_q, susp_q,
                                         tout_q, done_q, busy_q};
        `FPES_OFS_RDATA: avs_readdata <= {24'h000000, rdata_q};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= FPES_S_IDLE;
      op_q <= FPES_OP_NONE;
      step_q <= 3'd0;
      nsteps_q <= 3'd0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      tout_q <= 1'b0;
      susp_q <= 1'b0;
      sect_run_q <= 1'b0;
      ok_q <= 1'b0;
      rdata_q <= 8'h00;
      bc_start_q <= 1'b0;
      bc_wr_q <= 1'b0;
      bc_addr_q <= 18'h00000;
      bc_wdata_q <= 8'h00;
    end else begin
      bc_start_q <= 1'b0;
      case (st_q)
        FPES_S_IDLE: begin
          if (cmd_wr && cmd_op != FPES_OP_NONE &&
              (!susp_q || cmd_op == FPES_OP_RESUME ||
               cmd_op == FPES_OP_READ) &&
              (cmd_op != FPES_OP_SUSP || (sect_run_q && !susp_q)) &&
              (cmd_op != FPES_OP_RESUME || susp_q) &&
              (!sect_run_q || susp_q || cmd_op == FPES_OP_SUSP)) begin
            op_q <= cmd_op;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            tout_q <= 1'b0;
            ok_q <= 1'b0;
            step_q <= 3'd0;
            st_q <= FPES_S_WRITE;
            case (cmd_op)
              FPES_OP_PROG, FPES_OP_PROT: nsteps_q <= 3'd4;
              FPES_OP_CHIP, FPES_OP_SECT: nsteps_q <= 3'd6;
              FPES_OP_SUSP, FPES_OP_RESUME: nsteps_q <= 3'd1;
              default: nsteps_q <= 3'd0;
            endcase
            if (cmd_op == FPES_OP_READ) st_q <= FPES_S_FINAL;
          end
        end
        FPES_S_WRITE: begin
          if (bc_done && !bc_wr_q) rdata_q <= bc_rdata;
          if (!bc_busy && !bc_start_q) begin
            if (step_q == nsteps_q) begin
              st_q <= (op_q == FPES_OP_PROT) ? FPES_S_FINAL : FPES_S_POLL;
              if (op_q == FPES_OP_SECT) sect_run_q <= 1'b1;
              if (op_q == FPES_OP_RESUME) susp_q <= 1'b0;
            end else begin
              bc_start_q <= 1'b1;
              bc_wr_q <= 1'b1;
              if (nsteps_q == 3'd1) begin
                bc_addr_q <= `FPES_UNLOCK1_ADDR;
                bc_wdata_q <= (op_q == FPES_OP_SUSP) ? `FPES_SUSP_DATA
                                                     : `FPES_SECT_DATA;
              end else begin
                bc_addr_q <= seq_addr(op_q, step_q, addr_q);
                bc_wdata_q <= seq_data(op_q, step_q, data_q);
              end
              if (op_q == FPES_OP_PROT && step_q == 3'd3) begin
                bc_wr_q <= 1'b0;
                bc_addr_q <= (addr_q & `FPES_SECT_MASK) | `FPES_PROT_OFS;
              end
              step_q <= step_q + 3'd1;
            end
          end
        end
        FPES_S_POLL: begin
          if (!bc_busy && !bc_start_q && !bc_done) begin
            bc_start_q <= 1'b1;
            bc_wr_q <= 1'b0;
            bc_addr_q <= (op_q == FPES_OP_CHIP) ? 18'h00000 : addr_q;
          end
          if (bc_done) begin
            if (op_q == FPES_OP_PROG ? (bc_rdata[`FPES_POLL_BIT] ==
                                        data_q[`FPES_POLL_BIT])
                                     : bc_rdata[`FPES_POLL_BIT]) begin
              st_q <= FPES_S_FINAL;
              ok_q <= 1'b1;
              if (op_q == FPES_OP_SUSP) susp_q <= 1'b1;
              if (op_q == FPES_OP_SECT || op_q == FPES_OP_RESUME)
                sect_run_q <= 1'b0;
            end else if (bc_rdata[`FPES_TOUT_BIT]) begin
              tout_q <= 1'b1;
              st_q <= FPES_S_RESET;
              sect_run_q <= 1'b0;
              susp_q <= 1'b0;
            end
          end
        end
        FPES_S_RESET: begin
          if (!bc_busy && !bc_start_q) begin
            bc_start_q <= 1'b1;
            bc_wr_q <= 1'b1;
            bc_addr_q <= `FPES_UNLOCK1_ADDR;
            bc_wdata_q <= `FPES_RESET_DATA;
            st_q <= FPES_S_FINAL;
            op_q <= FPES_OP_NONE;
          end
        end
        FPES_S_FINAL: begin
          // one more read for full valid data
          if (bc_done && !bc_wr_q) rdata_q <= bc_rdata;
          if (!bc_busy && !bc_start_q) begin
            if (op_q == FPES_OP_NONE || op_q == FPES_OP_PROT ||
                op_q == FPES_OP_RESUME || op_q == FPES_OP_SUSP) begin
              st_q <= FPES_S_IDLE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              if (op_q == FPES_OP_RESUME) st_q <= FPES_S_POLL;
              if (op_q == FPES_OP_RESUME) busy_q <= 1'b1;
              if (op_q == FPES_OP_RESUME) op_q <= FPES_OP_SECT;
            end else begin
              bc_start_q <= 1'b1;
              bc_wr_q <= 1'b0;
              bc_addr_q <= addr_q;
              op_q <= FPES_OP_NONE;
            end
          end
        end
        default: st_q <= FPES_S_IDLE;
      endcase
    end
  end
endmodule

// >>> verif/fpes_host_asserts.sv
// Purpose: Flash pin timing checks on the host
// Assumes: Bus cycle phases of 12 clocks
// Notes:   Bound to fpes_host
`timescale 1ns/1ps
module fpes_host_chk (
  input wire logic        clk,             // Clock
  input wire logic        reset_n,         // Reset, active low
  input wire logic [3:0]  avs_address,     // Word address
  input wire logic        avs_read,        // Read request
  input wire logic        avs_write,       // Write request
  input wire logic [31:0] avs_writedata,   // Write data
  input wire logic [31:0] avs_readdata,    // Read data
  input wire logic        avs_waitrequest, // Stall
  input wire logic [17:0] flash_addr,      // Flash address
  input wire logic        chip_select_n,   // Chip select
  input wire logic        write_strobe_n,  // Write strobe
  input wire logic        output_strobe_n, // Output strobe
  input wire logic [7:0]  dq_out,          // Data out
  input wire logic        dq_oe_n,         // Drive enable, low drives
  input wire logic [7:0]  dq_in            // Data in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Flash strobes
  strobe_excl_a: assert property (write_strobe_n || output_strobe_n)
    else $error("both strobes low");
  strobe_sel_a: assert property (
    (!write_strobe_n || !output_strobe_n) |-> !chip_select_n)
    else $error("strobe without chip select");
  wr_setup_a: assert property (
    $fell(write_strobe_n) |-> $stable(flash_addr) && !dq_oe_n)
    else $error("address not set before write strobe");
  wr_pulse_a: assert property (
    $fell(write_strobe_n) |-> ##11 !write_strobe_n ##1 write_strobe_n)
    else $error("write strobe length wrong");
  wr_hold_a: assert property (
    !write_strobe_n |=> $stable(flash_addr) && $stable(dq_out))
    else $error("address or data moved under strobe");
  data_rise_a: assert property (
    $rose(write_strobe_n) |-> !chip_select_n && !dq_oe_n)
    else $error("data released at strobe rise");
  rd_pulse_a: assert property (
    $fell(output_strobe_n) |-> ##11 !output_strobe_n ##1 output_strobe_n)
    else $error("read strobe length wrong");
  rd_float_a: assert property (!output_strobe_n |-> dq_oe_n)
    else $error("host drives data while reading");
  cs_gap_a: assert property ($rose(chip_select_n) |=> chip_select_n)
    else $error("no idle cycle between bus cycles");
  cover property ($fell(write_strobe_n));
  cover property ($fell(output_strobe_n));
  cover property (avs_write && avs_address == 4'h0);
endmodule
bind fpes_host fpes_host_chk u_chk (.clk(clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .flash_addr(flash_addr),
  .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
  .output_strobe_n(output_strobe_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
  .dq_in(dq_in));

// >>> verif/fpes_flash_model.sv
// Purpose: Behavioural parallel flash facing the host
// Assumes: Commands parsed on write strobe edges
// Notes:   Busy status lasts BUSY_READS reads
`timescale 1ns/1ps
module fpes_flash_model #(
  parameter int         BUSY_READS = 3,     // Status reads while busy
  parameter logic [4:0] PROT_SECT  = 5'h1f  // Protected sector
) (
  input  wire logic [17:0] flash_addr,      // Address pins
  input  wire logic        chip_select_n,   // Chip select
  input  wire logic        write_strobe_n,  // Write strobe
  input  wire logic        output_strobe_n, // Output strobe
  input  wire logic [7:0]  dq_out,          // Data from host
  input  wire logic        fail_prog,       // Next program times out
  output logic      [7:0]  dq_in,           // Data to host
  output int               wr_count         // Accepted writes
);
  logic [7:0]  mem [int];
  logic [17:0] wa;
  logic [7:0]  pd, rd, m;
  logic [4:0]  es;
  int          step, cnt;
  logic        prog, sect, susp, idm, tout, stale, tgl;
  initial begin
    step = 0;
    cnt = 0;
    wr_count = 0;
    {prog, sect, susp, idm, tout, stale, tgl} = '0;
    {pd, rd, es} = '0;
  end
  // Released bus shows the inverted last value
  assign dq_in = (!chip_select_n && !output_strobe_n) ? rd : ~rd;
  always @(negedge write_strobe_n or negedge chip_select_n)
    if (!write_strobe_n && !chip_select_n) wa = flash_addr;
  // earlier rising edge; status valid from here
  always @(posedge write_strobe_n or posedge chip_select_n)
    if (!write_strobe_n || !chip_select_n) wr_cmd(wa, dq_out);
  task wr_cmd(input logic [17:0] a, input logic [7:0] d);
    wr_count++;
    if (tout) tout = d != 8'hf0;
    else if (cnt > 0 && !susp) susp = sect && d == 8'hb0;
    else if (susp) susp = d != 8'h30;
    else if (d == 8'hf0) begin
      step = 0;
      idm = 0;
    end else begin
      case (step)
        0, 4: step = (a == 18'h555 && d == 8'haa) ? step + 1 : 0;
        1, 5: step = (a == 18'haaa && d == 8'h55) ? step + 1 : 0;
        2: begin
          idm = a == 18'h555 && d == 8'h90;
          step = a != 18'h555 ? 0 : d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
        end
        3: begin
          m = mem.exists(a) ? mem[a] : 8'hff;
          mem[a] = m & d;
          pd = d;
          prog = 1;
          sect = 0;
          tout = fail_prog;
          cnt = fail_prog ? 0 : BUSY_READS;
          step = 0;
        end
        6: begin
          es = a[17:13];
          sect = d == 8'h30;
          prog = 0;
          if (d == 8'h10) mem.delete();
          if (sect) for (int k = 0; k < 8192; k++) mem.delete({es, 13'h0} + k);
          cnt = (d == 8'h10 || sect) ? BUSY_READS : 0;
          step = 0;
        end
        default: step = 0;
      endcase
    end
  endtask
  always @(negedge output_strobe_n) begin
    if (!chip_select_n) begin
      m = mem.exists(flash_addr) ? mem[flash_addr] : 8'hff;
      if (idm) rd = {7'h0, flash_addr[17:13] == PROT_SECT};
      else if (tout) begin
        rd = {~pd[7], tgl, 6'h20};
        tgl = ~tgl;
      end else if (cnt > 0 && !susp) begin
        rd = {prog ? ~pd[7] : 1'b0, tgl, 6'h0};
        tgl = ~tgl;
        cnt--;
        stale = cnt == 0;
      end else if (susp && flash_addr[17:13] == es) rd = 8'h80;
      // first ready read has stale low bits
      else if (stale) begin
        rd = {m[7], ~m[6:0]};
        stale = 0;
      end else rd = m;
    end
  end
endmodule

// >>> verif/fpes_host_bench.sv
// Purpose: Self-checking bench of the flash host
// Assumes: Read data taken at the edge waitrequest is seen low
// Notes:   Expected reads queued, compared by a monitor
`timescale 1ns/1ps
`include "fpes_regs.svh"
module fpes_host_bench import fpes_pkg::*; ;
  typedef struct {string n; logic [31:0] v; logic [31:0] k;} fpes_exp_t;
  localparam logic [31:0] ok_stat = 32'h12;
  logic        clk, reset_n, avs_read, avs_write, fail_prog;
  logic        avs_waitrequest, chip_select_n, write_strobe_n;
  logic        output_strobe_n, dq_oe_n;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, scratch;
  logic [17:0] flash_addr;
  logic [7:0]  dq_out, dq_in, rv;
  int          wr_count, wd, cyc, seed, mismatches, total_checks;
  fpes_exp_t   exp_q[$];
  fpes_exp_t   it;
  fpes_host dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_addr(flash_addr), .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
  fpes_flash_model flash (.flash_addr(flash_addr),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n), .dq_out(dq_out),
    .fail_prog(fail_prog), .dq_in(dq_in), .wr_count(wr_count));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task close_out;
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task avs_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task avs_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task expect_rd(input string n, input logic [3:0] a, input logic [31:0] v,
                 input logic [31:0] k);
    @(posedge clk);
    exp_q.push_back('{n, v & k, k});
    avs_rd(a, scratch);
  endtask
  task do_op(input fpes_op_t op, input logic [17:0] a, input logic [7:0] d);
    int w0;
    w0 = wr_count;
    avs_wr(`FPES_OFS_ADDR, {14'h0, a});
    avs_wr(`FPES_OFS_DATA, {24'h0, d});
    avs_wr(`FPES_OFS_CTRL, {29'h0, op});
    do avs_rd(`FPES_OFS_STAT, scratch);
    while (scratch[`FPES_STAT_BUSY] !== 1'b0);
    wd = wr_count - w0;
  endtask
  // ==========================================
  // Monitor of read results
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      it = exp_q.pop_front();
      cmp(it.n, it.v, avs_readdata & it.k);
    end
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      close_out();
    end
  end
  // ==========================================
  // Scenarios
  initial begin
    {reset_n, avs_read, avs_write, fail_prog} = '0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    {cyc, mismatches, total_checks} = '0;
    seed = 32'h5e17bf15;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    expect_rd("idle status", `FPES_OFS_STAT, 32'h0, 32'h1f);
    expect_rd("unmapped", 4'hf, 32'h0, 32'hffff_ffff);
    do_op(FPES_OP_CHIP, 18'h0, 8'h0);
    cmp("chip writes", 6, wd);
    expect_rd("chip status", `FPES_OFS_STAT, ok_stat, 32'h1f);
    rv = $random(seed);
    do_op(FPES_OP_PROG, 18'h22000, rv);
    cmp("program writes", 4, wd);
    expect_rd("program data", `FPES_OFS_RDATA, {24'h0, rv}, 32'hff);
    do_op(FPES_OP_PROG, 18'h01234, 8'h5a);
    do_op(FPES_OP_PROG, 18'h01234, 8'h0f);
    expect_rd("cleared bits", `FPES_OFS_RDATA, 32'h0a, 32'hff);
    do_op(FPES_OP_SECT, 18'h22010, 8'h0);
    cmp("sector writes", 6, wd);
    do_op(FPES_OP_READ, 18'h22000, 8'h0);
    expect_rd("erased byte", `FPES_OFS_RDATA, 32'hff, 32'hff);
    do_op(FPES_OP_READ, 18'h01234, 8'h0);
    expect_rd("other sector", `FPES_OFS_RDATA, 32'h0a, 32'hff);
    do_op(FPES_OP_SUSP, 18'h0, 8'h0);
    cmp("idle suspend", 0, wd);
    do_op(FPES_OP_RESUME, 18'h0, 8'h0);
    cmp("idle resume", 0, wd);
    fail_prog <= 1'b1;
    do_op(FPES_OP_PROG, 18'h01300, 8'h55);
    fail_prog <= 1'b0;
    cmp("timeout writes", 5, wd);
    expect_rd("timeout status", `FPES_OFS_STAT, 32'h4, 32'h15);
    do_op(FPES_OP_PROT, 18'h3e100, 8'h0);
    expect_rd("protected", `FPES_OFS_RDATA, 32'h1, 32'hff);
    do_op(FPES_OP_PROT, 18'h01234, 8'h0);
    expect_rd("unprotected", `FPES_OFS_RDATA, 32'h0, 32'hff);
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule
